// ===== sms_map.svh
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH
`define SMS_ADDR_W         8
`define SMS_OFS_STATUS     8'h10
`define SMS_OFS_FILL       8'h14
`define SMS_OFS_IRQ_EN     8'h18
`define SMS_BIT_XFER_DONE  0
`define SMS_BIT_DMA_DONE   1
`define SMS_BIT_TX_OVF     2
`define SMS_BIT_RX_UNF     3
`define SMS_BIT_PROG_ERR   4
`define SMS_BIT_DMA_RX_ERR 5
`define SMS_BIT_DMA_TX_ERR 6
`define SMS_FLAG_W         7
`define SMS_CNT_W          16
`define SMS_BUF_DEPTH      16'h0040
`define SMS_TX_ERR_RST     1'h1
`define SMS_IRQ_EN_RST     7'h00
`define SMS_STAT_MASK      7'h1f
`endif

// ===== sms_pkg.sv
package sms_pkg;
  typedef struct packed {
    logic        dma_en;
    logic        desc_en;
    logic        close_en;
    logic        dma_tx_act;
    logic        dma_rx_act;
  } sms_mode_s;

  typedef struct packed {
    logic        dma_tx_done;
    logic        dma_rx_done;
    logic        len_match;
    logic        last_desc_done;
    logic        stop_byte_done;
    logic        prog_err;
    logic        dma_tx_err;
    logic        dma_rx_err;
  } sms_evt_s;

  typedef struct packed {
    logic        tx_push;
    logic        tx_pop;
    logic        rx_push;
    logic        rx_pop;
  } sms_buf_s;

  typedef enum logic [1:0] {
    SMS_DMA_IDLE = 2'b00,
    SMS_DMA_WAIT = 2'b01
  } sms_dma_e;

  typedef struct packed {
    logic [6:0]  flags;
    logic [6:0]  irq_en;
    logic [15:0] rx_cnt;
    logic [15:0] tx_cnt;
    logic        tx_seen;
    logic        rx_seen;
    sms_dma_e    dma_st;
    logic [31:0] rdata;
    logic        irq;
    logic        tx_full;
    logic        rx_empty;
  } sms_state_s;
endpackage

// ===== sms_status.sv
`include "sms_map.svh"
module sms_status (
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  input  wire logic [7:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire sms_pkg::sms_mode_s     i_mode,
  input  wire sms_pkg::sms_evt_s      i_evt,
  input  wire sms_pkg::sms_buf_s      i_buf,
  output logic [31:0]                 o_rdata,
  output logic                        o_irq,
  output logic                        o_tx_full,
  output logic                        o_rx_empty
);
  import sms_pkg::*;

  sms_state_s s_q;
  sms_state_s s_d;

  function automatic logic [15:0] step(input logic [15:0] c, input logic up, input logic dn);
    logic [15:0] r;
    r = c;
    if (up && !dn) begin
      r = c + 16'h0001;
    end else if (dn && !up) begin
      r = c - 16'h0001;
    end
    return r;
  endfunction

  logic tx_full;
  logic rx_empty;
  logic tx_push_ok;
  logic tx_pop_ok;
  logic rx_push_ok;
  logic rx_pop_ok;
  logic dma_done;
  logic xfer_done;
  logic [6:0] set_v;
  logic [6:0] clr_v;

  assign tx_full    = (s_q.tx_cnt == `SMS_BUF_DEPTH);
  assign rx_empty   = (s_q.rx_cnt == 16'h0000);
  assign tx_push_ok = i_buf.tx_push && !tx_full;
  assign tx_pop_ok  = i_buf.tx_pop && (s_q.tx_cnt != 16'h0000);
  assign rx_push_ok = i_buf.rx_push && (s_q.rx_cnt != `SMS_BUF_DEPTH);
  assign rx_pop_ok  = i_buf.rx_pop && !rx_empty;

  always_comb begin
    logic tx_ok;
    logic rx_ok;
    tx_ok    = i_evt.dma_tx_done || s_q.tx_seen;
    rx_ok    = i_evt.dma_rx_done || s_q.rx_seen;
    dma_done = 1'b0;
    if (i_mode.dma_en) begin
      // wait for every active direction before reporting done
      if (i_mode.dma_tx_act && i_mode.dma_rx_act) begin
        dma_done = tx_ok && rx_ok;
      end else if (i_mode.dma_tx_act) begin
        dma_done = i_evt.dma_tx_done;
      end else if (i_mode.dma_rx_act) begin
        dma_done = i_evt.dma_rx_done;
      end
    end
  end

  always_comb begin
    xfer_done = i_evt.stop_byte_done;
    if (i_mode.desc_en) begin
      xfer_done = xfer_done || i_evt.last_desc_done;
    end else if (i_mode.dma_en) begin
      xfer_done = xfer_done || dma_done;
    end else begin
      xfer_done = xfer_done || i_evt.len_match;
    end
    if (i_mode.close_en && dma_done) begin
      xfer_done = 1'b1;
    end
  end

  always_comb begin
    set_v = 7'h00;
    set_v[`SMS_BIT_XFER_DONE] = xfer_done;
    set_v[`SMS_BIT_DMA_DONE]  = dma_done;
    set_v[`SMS_BIT_TX_OVF]    = i_buf.tx_push && tx_full;
    set_v[`SMS_BIT_RX_UNF]    = i_buf.rx_pop && rx_empty;
    set_v[`SMS_BIT_PROG_ERR]  = i_evt.prog_err;
    clr_v = 7'h00;
    if (i_wr && i_addr == `SMS_OFS_STATUS) begin
      clr_v = i_wdata[6:0] & `SMS_STAT_MASK;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.flags[4:0] = (s_q.flags[4:0] & ~clr_v[4:0]) | set_v[4:0];
    s_d.flags[`SMS_BIT_DMA_RX_ERR] = i_evt.dma_rx_err;
    s_d.flags[`SMS_BIT_DMA_TX_ERR] = i_evt.dma_tx_err;
    s_d.tx_cnt = step(s_q.tx_cnt, tx_push_ok, tx_pop_ok);
    s_d.rx_cnt = step(s_q.rx_cnt, rx_push_ok, rx_pop_ok);
    // level outputs registered from the next counts, so they move with the counts
    s_d.tx_full  = (s_d.tx_cnt == `SMS_BUF_DEPTH);
    s_d.rx_empty = (s_d.rx_cnt == 16'h0000);
    // partial DMA completion remembered until the other side finishes
    if (dma_done || !i_mode.dma_en) begin
      s_d.tx_seen = 1'b0;
      s_d.rx_seen = 1'b0;
      s_d.dma_st  = SMS_DMA_IDLE;
    end else begin
      s_d.tx_seen = s_q.tx_seen || i_evt.dma_tx_done;
      s_d.rx_seen = s_q.rx_seen || i_evt.dma_rx_done;
      s_d.dma_st  = (s_d.tx_seen || s_d.rx_seen) ? SMS_DMA_WAIT : SMS_DMA_IDLE;
    end
    if (i_wr && i_addr == `SMS_OFS_IRQ_EN) begin
      s_d.irq_en = i_wdata[6:0];
    end
    s_d.irq = |(s_d.flags & s_d.irq_en);
    s_d.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        `SMS_OFS_STATUS: begin
          s_d.rdata[6:0] = s_q.flags;
        end
        `SMS_OFS_FILL: begin
          s_d.rdata = {s_q.rx_cnt, s_q.tx_cnt};
        end
        `SMS_OFS_IRQ_EN: begin
          s_d.rdata[6:0] = s_q.irq_en;
        end
        default: begin
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q        <= '0;
      s_q.flags  <= {`SMS_TX_ERR_RST, 6'h00};
      s_q.irq_en <= `SMS_IRQ_EN_RST;
      s_q.rx_empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata    = s_q.rdata;
  assign o_irq      = s_q.irq;
  assign o_tx_full  = s_q.tx_full;
  assign o_rx_empty = s_q.rx_empty;

  AST_OVF_SET: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_buf.tx_push && tx_full) |=> s_q.flags[`SMS_BIT_TX_OVF]) else $error("overflow flag not set");
  AST_UNF_SET: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_buf.rx_pop && rx_empty) |=> s_q.flags[`SMS_BIT_RX_UNF]) else $error("underflow flag not set");
  AST_PROG_SET: assert property (@(posedge i_clk) disable iff (i_reset)
    i_evt.prog_err |=> s_q.flags[`SMS_BIT_PROG_ERR]) else $error("setup fault not set");
  AST_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.flags[`SMS_BIT_PROG_ERR] && !(i_wr && i_addr == `SMS_OFS_STATUS && i_wdata[4]))
    |=> s_q.flags[`SMS_BIT_PROG_ERR]) else $error("flag lost without clear");
  AST_CLEAR: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_wr && i_addr == `SMS_OFS_STATUS && i_wdata[3] && !(i_buf.rx_pop && rx_empty))
    |=> !s_q.flags[`SMS_BIT_RX_UNF]) else $error("clear ignored");
  AST_TOGETHER: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode.close_en && dma_done) |=> (s_q.flags[1:0] == 2'b11)) else $error("done flags split");
  AST_DMA_BOTH: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode.dma_en && i_mode.dma_tx_act && i_mode.dma_rx_act && !s_q.tx_seen && !s_q.rx_seen
     && i_evt.dma_tx_done && !i_evt.dma_rx_done) |-> !dma_done) else $error("early DMA done");
  AST_TX_CNT: assert property (@(posedge i_clk) disable iff (i_reset)
    (tx_push_ok && !tx_pop_ok) |=> s_q.tx_cnt == $past(s_q.tx_cnt) + 16'h0001) else $error("tx count");
  AST_IRQ: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.flags[0] && s_q.irq_en[0]) |-> o_irq) else $error("irq missing");
  AST_RDATA: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_rd && i_addr == `SMS_OFS_FILL) |=> o_rdata[31:16] == $past(s_q.rx_cnt)) else $error("rx count read");

  // reset checks run without the reset disable on purpose
  AST_TX_ERR_RST: assert property (@(posedge i_clk)
    i_reset |=> s_q.flags[`SMS_BIT_DMA_TX_ERR])
    else $error("tx fault reset value");

  AST_TX_ERR_COPY: assert property (@(posedge i_clk) disable iff (i_reset)
    1'b1 |=> s_q.flags[`SMS_BIT_DMA_TX_ERR] == $past(i_evt.dma_tx_err))
    else $error("tx fault not followed");

  AST_RX_ERR_RST: assert property (@(posedge i_clk)
    i_reset |=> !s_q.flags[`SMS_BIT_DMA_RX_ERR])
    else $error("rx fault reset value");

  AST_RX_ERR_COPY: assert property (@(posedge i_clk) disable iff (i_reset)
    1'b1 |=> s_q.flags[`SMS_BIT_DMA_RX_ERR] == $past(i_evt.dma_rx_err))
    else $error("rx fault not followed");

  AST_RST_CNT: assert property (@(posedge i_clk)
    i_reset |=> (s_q.tx_cnt == 16'h0000 && s_q.rx_cnt == 16'h0000 && o_rx_empty && !o_tx_full))
    else $error("counts not reset");

  AST_OVF_NOCNT: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_buf.tx_push && tx_full && !i_buf.tx_pop) |=> s_q.tx_cnt == $past(s_q.tx_cnt))
    else $error("overflow moved count");

  AST_UNF_NOCNT: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_buf.rx_pop && rx_empty && !i_buf.rx_push) |=> s_q.rx_cnt == $past(s_q.rx_cnt))
    else $error("underflow moved count");

  AST_DMA_SET: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode.dma_en && i_mode.dma_tx_act && !i_mode.dma_rx_act && i_evt.dma_tx_done) |=> s_q.flags[1])
    else $error("DMA done not set");

  AST_DMA_BOTH_DONE: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode.dma_en && i_mode.dma_tx_act && i_mode.dma_rx_act && s_q.tx_seen && i_evt.dma_rx_done)
    |=> s_q.flags[1])
    else $error("DMA done missing after both");

  AST_DMA_OFF: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_mode.dma_en |-> !dma_done)
    else $error("DMA done without DMA");

  AST_DESC_DMA: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode.desc_en && dma_done) |=> s_q.flags[1])
    else $error("DMA done suppressed");

  AST_MAN_DONE: assert property (@(posedge i_clk) disable iff (i_reset)
    (!i_mode.dma_en && !i_mode.desc_en && i_evt.len_match) |=> s_q.flags[0])
    else $error("manual done missing");

  AST_DMA_XFER: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode.dma_en && !i_mode.desc_en && dma_done) |=> s_q.flags[0])
    else $error("DMA transfer done missing");

  AST_DESC_LAST: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode.desc_en && i_evt.last_desc_done) |=> s_q.flags[0])
    else $error("last descriptor done missing");

  AST_DESC_EARLY: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_mode.desc_en && !i_evt.last_desc_done && !i_evt.stop_byte_done && !(i_mode.close_en && dma_done))
    |-> !xfer_done)
    else $error("early descriptor done");

  AST_STOP: assert property (@(posedge i_clk) disable iff (i_reset)
    i_evt.stop_byte_done |=> s_q.flags[0])
    else $error("stop done missing");

  AST_RX_CNT_UP: assert property (@(posedge i_clk) disable iff (i_reset)
    (rx_push_ok && !rx_pop_ok) |=> s_q.rx_cnt == $past(s_q.rx_cnt) + 16'h0001)
    else $error("rx count up");

  AST_TX_CNT_DN: assert property (@(posedge i_clk) disable iff (i_reset)
    (tx_pop_ok && !tx_push_ok) |=> s_q.tx_cnt == $past(s_q.tx_cnt) - 16'h0001)
    else $error("tx count down");

  AST_TX_BOUND: assert property (@(posedge i_clk) disable iff (i_reset)
    s_q.tx_cnt <= `SMS_BUF_DEPTH)
    else $error("tx count beyond depth");

  AST_RX_BOUND: assert property (@(posedge i_clk) disable iff (i_reset)
    s_q.rx_cnt <= `SMS_BUF_DEPTH)
    else $error("rx count beyond depth");

  AST_TX_RD: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_rd && i_addr == `SMS_OFS_FILL) |=> o_rdata[15:0] == $past(s_q.tx_cnt))
    else $error("tx count read");

  AST_RDATA_IDLE: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data without read");

  AST_IRQ_OFF: assert property (@(posedge i_clk) disable iff (i_reset)
    !(|(s_q.flags & s_q.irq_en)) |-> !o_irq)
    else $error("irq without cause");

  AST_IRQ_EN_WR: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_wr && i_addr == `SMS_OFS_IRQ_EN) |=> s_q.irq_en == $past(i_wdata[6:0]))
    else $error("irq enable write lost");

  AST_OVF_WINS: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_buf.tx_push && tx_full && i_wr && i_addr == `SMS_OFS_STATUS && i_wdata[2]) |=> s_q.flags[2])
    else $error("clear beat set");

  AST_CLR_OVF: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_wr && i_addr == `SMS_OFS_STATUS && i_wdata[2] && !(i_buf.tx_push && tx_full)) |=> !s_q.flags[2])
    else $error("overflow clear ignored");

  AST_CLR_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_q.flags[3] && i_wr && i_addr == `SMS_OFS_STATUS && !i_wdata[3]) |=> s_q.flags[3])
    else $error("zero write cleared flag");
endmodule // sms_status

// ===== sms_dma_model.sv
module sms_dma_model (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_go,
  input  wire logic [3:0] i_tx_dly,
  input  wire logic [3:0] i_rx_dly,
  output logic            o_tx_done,
  output logic            o_rx_done,
  output logic            o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_q;
  // each channel says done once the shared count reaches its own delay
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_q     <= 5'h0;
      o_busy    <= 1'b0;
      o_tx_done <= 1'b0;
      o_rx_done <= 1'b0;
    end else begin
      o_tx_done <= o_busy && cnt_q == {1'b0, i_tx_dly};
      o_rx_done <= o_busy && cnt_q == {1'b0, i_rx_dly};
      cnt_q     <= i_go ? 5'h0 : cnt_q + 5'h1;
      o_busy    <= i_go || (o_busy && cnt_q != 5'h10);
    end
  end
endmodule // sms_dma_model

// ===== tb_sms_status.sv
`include "sms_map.svh"
module tb_sms_status;
  timeunit 1ns;
  timeprecision 1ns;
  import sms_pkg::*;
  logic        i_clk, i_reset, i_wr, i_rd, go, m_tx, m_rx, busy;
  logic        o_irq, o_tx_full, o_rx_empty;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata;
  sms_mode_s   i_mode;
  sms_evt_s    evt, i_evt;
  sms_buf_s    i_buf;
  int          fails, tests_run;
  always_comb begin
    i_evt             = evt;
    i_evt.dma_tx_done = evt.dma_tx_done | m_tx;
    i_evt.dma_rx_done = evt.dma_rx_done | m_rx;
  end
  sms_status i_dut (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .i_mode, .i_evt, .i_buf,
    .o_rdata, .o_irq, .o_tx_full, .o_rx_empty);
  sms_dma_model i_dma (.i_clk, .i_reset, .i_go(go), .i_tx_dly(4'h1), .i_rx_dly(4'hc),
    .o_tx_done(m_tx), .o_rx_done(m_rx), .o_busy(busy));
  task automatic summarize();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic pulse(input sms_evt_s e);
    @(posedge i_clk);
    evt <= e;
    @(posedge i_clk);
    evt <= '0;
  endtask
  task automatic bufp(input sms_buf_s b, input int n);
    @(posedge i_clk);
    i_buf <= b;
    repeat (n) @(posedge i_clk);
    i_buf <= '0;
    #1;
  endtask
  task automatic wait_lvl(ref logic s, input logic v);
    for (int n = 0; n < 40; n++) begin
      @(posedge i_clk);
      #1;
      if (s === v) return;
    end
    fails++;
    summarize();
  endtask
  task automatic t_reset();
    rd_chk(`SMS_OFS_STATUS, 32'h60);
    wr_reg(`SMS_OFS_STATUS, 32'h60);
    rd_chk(`SMS_OFS_STATUS, 32'h60);
    rd_chk(`SMS_OFS_FILL, 32'h0);
    rd_chk(`SMS_OFS_IRQ_EN, 32'h0);
    pulse('0);
    rd_chk(`SMS_OFS_STATUS, 32'h0);
  endtask
  task automatic t_sticky();
    pulse(8'h04);
    rd_chk(`SMS_OFS_STATUS, 32'h10);
    wr_reg(`SMS_OFS_STATUS, 32'h0f);
    rd_chk(`SMS_OFS_STATUS, 32'h10);
    fork
      wr_reg(`SMS_OFS_STATUS, 32'h10);
      pulse(8'h04);
    join
    rd_chk(`SMS_OFS_STATUS, 32'h10);
    wr_reg(`SMS_OFS_STATUS, 32'h10);
    rd_chk(`SMS_OFS_STATUS, 32'h0);
  endtask
  task automatic t_buf();
    bufp(4'h8, 64);
    chk(o_tx_full, 32'h1);
    bufp(4'h8, 1);
    rd_chk(`SMS_OFS_STATUS, 32'h4);
    bufp(4'h1, 1);
    chk(o_rx_empty, 32'h1);
    rd_chk(`SMS_OFS_STATUS, 32'hc);
    bufp(4'h2, 3);
    rd_chk(`SMS_OFS_FILL, 32'h3_0040);
    bufp(4'h1, 3);
    chk(o_rx_empty, 32'h1);
    wr_reg(`SMS_OFS_STATUS, 32'h1f);
  endtask
  task automatic t_dma();
    i_mode <= 5'h13;
    @(posedge i_clk);
    go     <= 1'b1;
    @(posedge i_clk);
    go     <= 1'b0;
    wait_lvl(m_tx, 1'b1);
    rd_chk(`SMS_OFS_STATUS, 32'h0);
    wait_lvl(busy, 1'b0);
    rd_chk(`SMS_OFS_STATUS, 32'h3);
    wr_reg(`SMS_OFS_STATUS, 32'h3);
  endtask
  task automatic t_flag(input sms_mode_s m, input sms_evt_s e, input logic [31:0] exp);
    i_mode <= m;
    pulse(e);
    rd_chk(`SMS_OFS_STATUS, exp);
    wr_reg(`SMS_OFS_STATUS, 32'h3);
  endtask
  task automatic t_irq();
    pulse(8'h20);
    wr_reg(`SMS_OFS_IRQ_EN, 32'h1);
    wait_lvl(o_irq, 1'b1);
    wr_reg(`SMS_OFS_IRQ_EN, 32'h0);
    wait_lvl(o_irq, 1'b0);
    wr_reg(`SMS_OFS_IRQ_EN, 32'h1);
    wr_reg(`SMS_OFS_STATUS, 32'h1);
    wait_lvl(o_irq, 1'b0);
    rd_chk(8'h1c, 32'h0);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    i_reset = 1'b1;
    {i_wr, i_rd, go, i_addr, i_wdata, i_mode, i_buf} = '0;
    evt     = 8'h03;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_sticky();
    t_buf();
    t_dma();
    t_flag(5'h1e, 8'h80, 32'h3);
    t_flag(5'h1a, 8'h80, 32'h2);
    t_flag(5'h08, 8'h10, 32'h1);
    t_flag(5'h00, 8'h20, 32'h1);
    t_flag(5'h00, 8'h08, 32'h1);
    t_irq();
    summarize();
  end
endmodule // tb_sms_status
